/* pclvd_top.v */
// Purpose: Power-on-clear reset and low-voltage detector control logic
// Assumes: Analog comparators sit outside and arrive as asynchronous levels
// Notes:   Registers over AXI4-Lite; two interrupt outputs (DETECTOR_INTERRUPT pulse, masked IRQ); one clock
//
// Functional notes
// - Low mode: hold reset until supply passes low
// - Low mode: reset follows supply below low level
// - Upper mode: hold reset until supply passes upper
// - Upper mode: release only at upper level again
// - Upper mode: stabilization wait before release
// - Compare supply or external pin, proper result
// - Bit 2 selects supply or external source
// - Bit 1 set: reset while input below level
// - Bit 1 clear: interrupt on every crossing
// - Bit 0 reads live below-level state
// - Detector reset sets cause bit 0
// - Sixteen selectable supply levels to comparator
// - Power-on reset clears whole cause register
// - Enable starts detector; disabled flag reads zero
// - Non-detector reset clears control; detector reset keeps
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`include "pclvd_defines.vh"

module pclvd_top #(
  parameter STAB_CYCLES = `PCLVD_STAB_MIN_CYC
)(
  input  wire        CLOCK,
  input  wire        RESETN,
  input  wire        POC_THRESHOLD_SELECT,
  input  wire        SUPPLY_ABOVE_POC_LOW,
  input  wire        SUPPLY_ABOVE_POC_UPPER,
  input  wire        SUPPLY_BELOW_DETECT,
  input  wire        EXTERNAL_LEVEL_BELOW,
  output wire [3:0]  DETECT_LEVEL_SELECT,
  output wire        INTERNAL_RESET,
  output wire        DETECTOR_RESET,
  output wire        DETECTOR_INTERRUPT,
  output wire        IRQ,
  input  wire [3:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [3:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  localparam POC_HOLD = 2'h0;
  localparam POC_WAIT = 2'h1;
  localparam POC_RUN  = 2'h2;

  // ----------------------------------------------------------------
  // Comparator synchronizers
  // ----------------------------------------------------------------
  reg  [4:0] sync1_ff;
  reg  [4:0] sync2_ff;

  // Two flops per comparator level and for the option pin
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end
    else
    begin
      sync1_ff <= {POC_THRESHOLD_SELECT, EXTERNAL_LEVEL_BELOW, SUPPLY_BELOW_DETECT,
                   SUPPLY_ABOVE_POC_UPPER, SUPPLY_ABOVE_POC_LOW};
      sync2_ff <= sync1_ff;
    end
  end

  wire above_low   = sync2_ff[0];
  wire above_upper = sync2_ff[1];
  wire sup_below   = sync2_ff[2];
  wire ext_below   = sync2_ff[3];
  wire upper_mode  = sync2_ff[4];  // Read only in hold, same latency as the levels

  // ----------------------------------------------------------------
  // Power-on-clear sequencer
  // ----------------------------------------------------------------
  reg  [1:0]  poc_state_ff;
  reg  [1:0]  nxt_poc_state;
  reg  [31:0] stab_cnt_ff;
  reg  [31:0] nxt_stab_cnt;

  // Release conditions and stabilization wait
  always @*
  begin
    nxt_poc_state = poc_state_ff;
    nxt_stab_cnt  = stab_cnt_ff;
    case (poc_state_ff)
      POC_HOLD:
      begin
        nxt_stab_cnt = 32'h0;
        if (above_low && !upper_mode)
          nxt_poc_state = POC_RUN;
        else if (above_low && upper_mode)
          nxt_poc_state = POC_WAIT;
      end
      POC_WAIT:
      begin
        if (!above_low)
          nxt_poc_state = POC_HOLD;
        else if (stab_cnt_ff < STAB_CYCLES)
          nxt_stab_cnt = stab_cnt_ff + 32'h1;
        else if (above_upper)
          nxt_poc_state = POC_RUN;
      end
      POC_RUN:
      begin
        if (!above_low)
          nxt_poc_state = POC_HOLD;
      end
      default:
        nxt_poc_state = POC_HOLD;
    endcase
  end

  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      poc_state_ff <= POC_HOLD;
      stab_cnt_ff  <= 32'h0;
    end
    else
    begin
      poc_state_ff <= nxt_poc_state;
      stab_cnt_ff  <= nxt_stab_cnt;
    end
  end

  wire poc_reset = (poc_state_ff != POC_RUN);

  // ----------------------------------------------------------------
  // Detector registers and logic
  // ----------------------------------------------------------------
  reg        enable_ff;
  reg        source_ff;
  reg        action_ff;
  reg  [3:0] level_ff;
  reg        cause_ff;
  reg        below_prev_ff;
  reg  [1:0] stat_ff;
  reg  [1:0] mask_ff;

  wire monitored_below = source_ff ? ext_below : sup_below;
  wire below_level_flag = enable_ff & monitored_below;
  wire det_reset = below_level_flag & action_ff;
  wire crossing = enable_ff & ~action_ff & (below_level_flag != below_prev_ff);

  assign DETECT_LEVEL_SELECT = level_ff;
  assign DETECTOR_RESET      = det_reset;
  assign INTERNAL_RESET      = poc_reset | det_reset;
  assign DETECTOR_INTERRUPT  = crossing;
  assign IRQ                 = |(stat_ff & mask_ff);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  reg        aw_got_ff;
  reg        w_got_ff;
  reg  [3:0] awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0] wstrb_ff;
  reg        bvalid_ff;
  reg  [1:0] bresp_ff;
  reg        rvalid_ff;
  reg  [1:0] rresp_ff;
  reg  [31:0] rdata_ff;

  assign S_AXI_AWREADY = ~aw_got_ff & ~bvalid_ff;
  assign S_AXI_WREADY  = ~w_got_ff & ~bvalid_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = ~rvalid_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;

  wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs  = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  wire wr_go = aw_got_ff & w_got_ff;
  wire wr_ctrl  = wr_go && (awaddr_ff == `PCLVD_OFS_CTRL) && wstrb_ff[0];
  wire wr_level = wr_go && (awaddr_ff == `PCLVD_OFS_LEVEL) && wstrb_ff[0];
  wire wr_stat  = wr_go && (awaddr_ff == `PCLVD_OFS_STATUS);
  wire wr_ok    = (awaddr_ff == `PCLVD_OFS_CTRL) || (awaddr_ff == `PCLVD_OFS_LEVEL) ||
                  (awaddr_ff == `PCLVD_OFS_CAUSE) || (awaddr_ff == `PCLVD_OFS_STATUS);

  // Write path: capture address and data in any order, answer after both
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {S_AXI_AWADDR[3:2], 2'h0};
      end
      if (w_hs)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? 2'h0 : 2'h2;
      end
      else if (bvalid_ff && S_AXI_BREADY)
        bvalid_ff <= 1'b0;
    end
  end

  // Read path: one-cycle answer, unmapped gives SLVERR
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= 2'h0;
    end
    else if (ar_hs)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= 2'h0;
      case ({S_AXI_ARADDR[3:2], 2'h0})
        `PCLVD_OFS_CTRL:
          rdata_ff <= {24'h0, enable_ff, 4'h0, source_ff, action_ff, below_level_flag};
        `PCLVD_OFS_LEVEL:
          rdata_ff <= {28'h0, level_ff};
        `PCLVD_OFS_CAUSE:
          rdata_ff <= {31'h0, cause_ff};
        `PCLVD_OFS_STATUS:
          rdata_ff <= {22'h0, mask_ff, 6'h0, stat_ff};
        default:
        begin
          rdata_ff <= 32'h0;
          rresp_ff <= 2'h2;
        end
      endcase
    end
    else if (rvalid_ff && S_AXI_RREADY)
      rvalid_ff <= 1'b0;
  end

  // Control and level registers: kept through a detector reset
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      enable_ff <= 1'b0;
      source_ff <= 1'b0;
      action_ff <= 1'b0;
      level_ff  <= `PCLVD_LEVEL_RST;
    end
    else if (poc_reset)
    begin
      enable_ff <= 1'b0;
      source_ff <= 1'b0;
      action_ff <= 1'b0;
      level_ff  <= `PCLVD_LEVEL_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        enable_ff <= wdata_ff[`PCLVD_CTRL_ENABLE];
        source_ff <= wdata_ff[`PCLVD_CTRL_SOURCE];
        action_ff <= wdata_ff[`PCLVD_CTRL_ACTION];
      end
      if (wr_level)
        level_ff <= wdata_ff[3:0];
    end
  end

  // Cause flag, crossing history and interrupt status
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cause_ff      <= 1'b0;
      below_prev_ff <= 1'b0;
      stat_ff       <= 2'h0;
      mask_ff       <= 2'h0;
    end
    else
    begin
      below_prev_ff <= below_level_flag;
      if (poc_reset)
        cause_ff <= 1'b0;
      else if (det_reset)
        cause_ff <= 1'b1;
      if (wr_stat && wstrb_ff[1])
        mask_ff <= wdata_ff[`PCLVD_STAT_MASK_LO +: 2];
      // Set wins over write-one-to-clear
      stat_ff[0] <= crossing | (stat_ff[0] & ~(wr_stat & wstrb_ff[0] & wdata_ff[0]));
      stat_ff[1] <= det_reset | (stat_ff[1] & ~(wr_stat & wstrb_ff[0] & wdata_ff[1]));
    end
  end

endmodule // pclvd_top

/* pclvd_defines.vh */
// Purpose: Constants for the power-on-clear and low-voltage detect block
// Assumes: 100 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses; each register is one aligned word
`ifndef PCLVD_DEFINES_VH
`define PCLVD_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCLVD_OFS_CTRL    4'h0
`define PCLVD_OFS_LEVEL   4'h4
`define PCLVD_OFS_CAUSE   4'h8
`define PCLVD_OFS_STATUS  4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCLVD_CTRL_ENABLE  7
`define PCLVD_CTRL_SOURCE  2
`define PCLVD_CTRL_ACTION  1
`define PCLVD_CTRL_FLAG    0
`define PCLVD_CAUSE_LVD    0
`define PCLVD_STAT_MASK_LO 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCLVD_CTRL_RST   8'h00
`define PCLVD_LEVEL_RST  4'h0
`define PCLVD_CAUSE_RST  8'h00

// ----------------------------------------------------------------
// Timing: stabilization wait in microseconds, clock in MHz
// ----------------------------------------------------------------
`define PCLVD_CLK_MHZ       100
`define PCLVD_STAB_MIN_US   1930
`define PCLVD_STAB_MAX_US   5390
`define PCLVD_STAB_MIN_CYC  (`PCLVD_STAB_MIN_US * `PCLVD_CLK_MHZ)
`define PCLVD_STAB_MAX_CYC  (`PCLVD_STAB_MAX_US * `PCLVD_CLK_MHZ)

`endif

/* pclvd_props.sv */
// Purpose: Port assertions for pclvd_top
// Assumes: Bound to pclvd_top; one clock
// Notes:   Comparator inputs pass a two-flop synchronizer
`timescale 1ns/1ns
module pclvd_props #(
  parameter STAB_CYCLES = 20
)(
  input wire CLOCK,
  input wire RESETN,
  input wire POC_THRESHOLD_SELECT,
  input wire SUPPLY_ABOVE_POC_LOW,
  input wire SUPPLY_ABOVE_POC_UPPER,
  input wire SUPPLY_BELOW_DETECT,
  input wire EXTERNAL_LEVEL_BELOW,
  input wire INTERNAL_RESET,
  input wire DETECTOR_RESET,
  input wire DETECTOR_INTERRUPT,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);
  // Low comparator rises in upper mode
  sequence s_low_rise;
    $rose(SUPPLY_ABOVE_POC_LOW) && POC_THRESHOLD_SELECT;
  endsequence
  property p_det_rst; DETECTOR_RESET |-> INTERNAL_RESET; endproperty
  a_det_rst: assert property (p_det_rst) else $error("detector reset missing");
  property p_int_pulse; DETECTOR_INTERRUPT |=> !DETECTOR_INTERRUPT; endproperty
  a_int_pulse: assert property (p_int_pulse) else $error("interrupt too long");
  property p_low_hold; !SUPPLY_ABOVE_POC_LOW [*5] |-> INTERNAL_RESET; endproperty
  a_low_hold: assert property (p_low_hold) else $error("no reset at low supply");
  property p_sync; $rose(DETECTOR_RESET) |-> $past(SUPPLY_BELOW_DETECT, 2) || $past(EXTERNAL_LEVEL_BELOW, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("unsynced detector reset");
  property p_up_rel; $fell(INTERNAL_RESET) && POC_THRESHOLD_SELECT |-> $past(SUPPLY_ABOVE_POC_UPPER, 2); endproperty
  a_up_rel: assert property (p_up_rel) else $error("release below upper level");
  property p_stab; s_low_rise |-> INTERNAL_RESET [*8]; endproperty
  a_stab: assert property (p_stab) else $error("wait too short");
  property p_b_done; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer repeated");
  property p_r_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
endmodule // pclvd_props

/* pclvd_supply.sv */
// Purpose: Comparator model for supply and level pin
// Assumes: Voltages in millivolts, set by the bench
// Notes:   Outputs settle off the clock edge
`timescale 1ns/1ns
module pclvd_supply #(
  parameter POC_LO   = 1590,
  parameter POC_UP   = 2700,
  parameter EXT_REF  = 1210,
  parameter LVL_TOP  = 4240,
  parameter LVL_STEP = 155
)(
  input  int        supply_mv,
  input  int        ext_mv,
  input  wire [3:0] level_sel,
  output wire       above_lo,
  output wire       above_up,
  output wire       below_det,
  output wire       ext_below
);
  // Thresholds; level table as a linear ramp
  assign #3 above_lo  = supply_mv >= POC_LO;
  assign #3 above_up  = supply_mv >= POC_UP;
  assign #3 below_det = supply_mv < LVL_TOP - LVL_STEP * level_sel;
  assign #3 ext_below = ext_mv < EXT_REF;
endmodule // pclvd_supply

/* pclvd_top_tb.sv */
// Purpose: Self-checking bench for pclvd_top
// Assumes: pclvd_supply models the comparators
// Notes:   Short wait count keeps the run brief
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: compare failed", $time); end end
module pclvd_top_tb;
  reg         clk = 1'b0, rst_n = 1'b0, thr = 1'b0, awv = 1'b0, wv = 1'b0;
  reg         brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  reg  [3:0]  awa = 4'h0, ara = 4'h0, lvl;
  reg  [31:0] wd = 32'h0, rv, seed = 32'd48964;
  reg  [1:0]  br, rr;
  int         sup = 0, ext = 1500, fail_count = 0, cmp_count = 0, n_int = 0;
  wire        alo, aup, bdet, xbl, irst, drst, dint, irq, awr, wrr, bv, arr, rvl;
  wire [3:0]  lsel;
  wire [31:0] rdd;
  wire [1:0]  brs, rrs;
  // Clock and crossing pulse count
  always #5 clk = ~clk;
  always @(posedge clk) if (dint === 1'b1) n_int <= n_int + 1;
  pclvd_top #(.STAB_CYCLES(20)) dut_u (.CLOCK(clk), .RESETN(rst_n), .POC_THRESHOLD_SELECT(thr),
    .SUPPLY_ABOVE_POC_LOW(alo), .SUPPLY_ABOVE_POC_UPPER(aup), .SUPPLY_BELOW_DETECT(bdet),
    .EXTERNAL_LEVEL_BELOW(xbl), .DETECT_LEVEL_SELECT(lsel), .INTERNAL_RESET(irst), .DETECTOR_RESET(drst),
    .DETECTOR_INTERRUPT(dint), .IRQ(irq), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(brs),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rvl), .S_AXI_RREADY(rrdy));
  pclvd_supply sup_u (.supply_mv(sup), .ext_mv(ext), .level_sel(lsel), .above_lo(alo),
    .above_up(aup), .below_det(bdet), .ext_below(xbl));
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction
  // Control readback from enable, source, action
  function automatic [7:0] ctl(input [2:0] c, input b);
    ctl = {c[2], 4'h0, c[1:0], b & c[2]};
  endfunction
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do
      begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wrr) wv <= 1'b0;
      end while (bv !== 1'b1);
      br = brs;
      brdy <= 1'b0;
    end
  endtask
  task rd(input [3:0] a);
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do
      begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
      end while (rvl !== 1'b1);
      rv = rdd;
      rr = rrs;
      rrdy <= 1'b0;
    end
  endtask
  task wrst(input v);
    begin
      repeat (100) if (irst !== v) @(posedge clk);
      `CHK(irst, v)
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Watchdog
  initial
  begin
    #100000;
    fail_count++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    w(5);
    rst_n <= 1'b1;
    w(10);
    `CHK(irst, 1'b1)
    sup = 3300;
    wrst(1'b0);
    rd(4'h8);
    `CHK(rv[7:0], 8'h00)
    sup = 1000;
    wrst(1'b1);
    sup = 3300;
    wrst(1'b0);
    w(20);
    lvl = 4'(xs());
    wr(4'h4, {28'h0, lvl});
    `CHK(lsel, lvl)
    `CHK(br, 2'h0)
    wr(4'hc, 32'h300);
    wr(4'h0, 32'h80);
    sup = 1600 + int'(xs() % 250);
    repeat (50) if (irq !== 1'b1) @(posedge clk);
    `CHK(irq, 1'b1)
    rd(4'h0);
    `CHK(rv[7:0], ctl(3'b100, 1'b1))
    wr(4'hc, 32'h301);
    `CHK(irq, 1'b0)
    sup = 4500;
    repeat (50) if (irq !== 1'b1) @(posedge clk);
    `CHK(irq, 1'b1)
    `CHK(n_int, 2)
    wr(4'hc, 32'h1);
    sup = 1700;
    w(20);
    `CHK(irq, 1'b0)
    rd(4'hc);
    `CHK(rv[9:0], 10'h001)
    sup = 4500;
    w(20);
    wr(4'h0, 32'h0);
    sup = 1700;
    w(20);
    rd(4'h0);
    `CHK(rv[7:0], ctl(3'b000, 1'b1))
    `CHK(n_int, 4)
    wr(4'h0, 32'h86);
    w(20);
    `CHK(irst, 1'b0)
    ext = 1000;
    wrst(1'b1);
    `CHK(drst, 1'b1)
    ext = 1500;
    wrst(1'b0);
    rd(4'h8);
    `CHK(rv[0], 1'b1)
    `CHK(rr, 2'h0)
    rd(4'h0);
    `CHK(rv[7:0], ctl(3'b111, 1'b0))
    rst_n <= 1'b0;
    thr <= 1'b1;
    sup = 0;
    w(5);
    rst_n <= 1'b1;
    sup = 2000;
    w(40);
    `CHK(irst, 1'b1)
    sup = 3300;
    wrst(1'b0);
    rd(4'h0);
    `CHK(rv[7:0], 8'h00)
    sup = 1000;
    wrst(1'b1);
    sup = 2000;
    w(40);
    `CHK(irst, 1'b1)
    sup = 3300;
    wrst(1'b0);
    sup = 1000;
    wrst(1'b1);
    sup = 3300;
    w(15);
    `CHK(irst, 1'b1)
    wrst(1'b0);
    give_verdict;
  end
endmodule // pclvd_top_tb
bind pclvd_top pclvd_props #(.STAB_CYCLES(STAB_CYCLES)) chk_u (.CLOCK(CLOCK), .RESETN(RESETN),
  .POC_THRESHOLD_SELECT(POC_THRESHOLD_SELECT), .SUPPLY_ABOVE_POC_LOW(SUPPLY_ABOVE_POC_LOW),
  .SUPPLY_ABOVE_POC_UPPER(SUPPLY_ABOVE_POC_UPPER), .SUPPLY_BELOW_DETECT(SUPPLY_BELOW_DETECT),
  .EXTERNAL_LEVEL_BELOW(EXTERNAL_LEVEL_BELOW), .INTERNAL_RESET(INTERNAL_RESET),
  .DETECTOR_RESET(DETECTOR_RESET), .DETECTOR_INTERRUPT(DETECTOR_INTERRUPT), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID));
